// *** logic/fftc_core.sv ***
`timescale 1ns/1ps
`include "fftc_params.svh"

module fftc_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic input_write_strobe,
  input wire logic [15:0] input_real_bus,
  input wire logic [15:0] input_imag_bus,
  input wire logic result_read_strobe,
  output logic [15:0] result_real_bus,
  output logic [15:0] result_imag_bus,
  output logic result_frame,
  output logic done_pulse,
  output logic early_complete_pulse,
  output logic busy,
  output logic arith_overflow_flag,
  output logic mode_sample_pulse,
  output logic io_cycle_strobe,
  output logic early_io_cycle_strobe,
  output logic irq
);
  import fftc_pkg::*;

  // ****************************************************************
  // Register file over AXI4-Lite
  // ****************************************************************
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic scale_sel_reg, scale_sel_next;
  logic dir_sel_reg, dir_sel_next;
  logic memcfg_select_first_reg, memcfg_select_first_next;
  logic memcfg_select_second_reg, memcfg_select_second_next;
  logic [`FFTC_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`FFTC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic wr_go, rd_go, start_req, core_reset_in;
  logic [`FFTC_IRQ_W-1:0] irq_set;
  logic [31:0] wr_addr, rd_addr;
  fftc_memcfg_t memcfg;
  fftc_state_t state_reg, state_next;
  logic scale_reg, scale_next;
  logic dir_reg, dir_next;
  logic ovf_reg, ovf_next;

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ~rvalid_reg;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wr_addr = {s_axi_awaddr[31:2], 2'b00};
  assign rd_addr = {s_axi_araddr[31:2], 2'b00};
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign start_req = wr_go && wr_addr == `FFTC_ADDR_CTRL && s_axi_wstrb[0] &&
                     s_axi_wdata[`FFTC_CTRL_START];
  assign core_reset_in = wr_go && wr_addr == `FFTC_ADDR_CTRL && s_axi_wstrb[0] &&
                         s_axi_wdata[`FFTC_CTRL_CORE_RESET];
  assign irq = |(irq_stat_reg & irq_mask_reg);
  assign memcfg = fftc_memcfg_t'({memcfg_select_first_reg, memcfg_select_second_reg});

  always_comb
  begin
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    scale_sel_next = scale_sel_reg;
    dir_sel_next = dir_sel_reg;
    memcfg_select_first_next = memcfg_select_first_reg;
    memcfg_select_second_next = memcfg_select_second_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_go)
    begin
      bvalid_next = 1'b1;
      bresp_next = `FFTC_RESP_OKAY;
      unique case (wr_addr)
        `FFTC_ADDR_CTRL:
          if (s_axi_wstrb[0])
          begin
            scale_sel_next = s_axi_wdata[`FFTC_CTRL_SCALE];
            dir_sel_next = s_axi_wdata[`FFTC_CTRL_DIR];
            memcfg_select_first_next = s_axi_wdata[`FFTC_CTRL_CFG_FIRST];
            memcfg_select_second_next = s_axi_wdata[`FFTC_CTRL_CFG_SECOND];
          end
        `FFTC_ADDR_STATUS: ;
        `FFTC_ADDR_IRQ_STATUS:
          if (s_axi_wstrb[0])
            irq_stat_next = irq_stat_reg & ~s_axi_wdata[`FFTC_IRQ_W-1:0];
        `FFTC_ADDR_IRQ_MASK:
          if (s_axi_wstrb[0])
            irq_mask_next = s_axi_wdata[`FFTC_IRQ_W-1:0];
        default:
          bresp_next = `FFTC_RESP_SLVERR;
      endcase
    end
    // A clear in the same cycle as a new event never hides the event.
    irq_stat_next = irq_stat_next | irq_set;
    if (rd_go)
    begin
      rvalid_next = 1'b1;
      rresp_next = `FFTC_RESP_OKAY;
      rdata_next = '0;
      unique case (rd_addr)
        `FFTC_ADDR_CTRL:
        begin
          rdata_next[`FFTC_CTRL_SCALE] = scale_sel_reg;
          rdata_next[`FFTC_CTRL_DIR] = dir_sel_reg;
          rdata_next[`FFTC_CTRL_CFG_FIRST] = memcfg_select_first_reg;
          rdata_next[`FFTC_CTRL_CFG_SECOND] = memcfg_select_second_reg;
        end
        `FFTC_ADDR_STATUS:
        begin
          rdata_next[`FFTC_STAT_BUSY] = busy;
          rdata_next[`FFTC_STAT_OVF] = ovf_reg;
          rdata_next[`FFTC_STAT_FRAME] = result_frame;
          rdata_next[`FFTC_STAT_SCALE] = scale_reg;
          rdata_next[`FFTC_STAT_DIR] = dir_reg;
        end
        `FFTC_ADDR_IRQ_STATUS:
          rdata_next[`FFTC_IRQ_W-1:0] = irq_stat_reg;
        `FFTC_ADDR_IRQ_MASK:
          rdata_next[`FFTC_IRQ_W-1:0] = irq_mask_reg;
        default:
          rresp_next = `FFTC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FFTC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `FFTC_RESP_OKAY;
      rdata_reg <= '0;
      scale_sel_reg <= 1'b0;
      dir_sel_reg <= 1'b1;
      memcfg_select_first_reg <= 1'b0;
      memcfg_select_second_reg <= 1'b1;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end
    else
    begin
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      scale_sel_reg <= scale_sel_next;
      dir_sel_reg <= dir_sel_next;
      memcfg_select_first_reg <= memcfg_select_first_next;
      memcfg_select_second_reg <= memcfg_select_second_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ****************************************************************
  // Transform sequencer and sample memories
  // ****************************************************************
  fftc_cplx_t in_mem [`FFTC_PTS];
  fftc_cplx_t in_next [`FFTC_PTS];
  fftc_cplx_t work_mem [`FFTC_PTS];
  fftc_cplx_t work_next [`FFTC_PTS];
  fftc_cplx_t out_reg, out_next;
  logic [5:0] wr_ptr_reg, wr_ptr_next;
  logic [5:0] rd_idx_reg, rd_idx_next;
  logic [1:0] pass_reg, pass_next;
  logic [3:0] fly_reg, fly_next;
  logic [2:0] lead_reg, lead_next;
  logic [5:0] fly_idx [4];
  fftc_quad_t fly_in, fly_out;
  logic fly_ovf;
  logic continuous;

  assign continuous = memcfg == FFTC_CFG_DUAL || memcfg == FFTC_CFG_TRIPLE;
  assign busy = state_reg != FFTC_IDLE;
  assign mode_sample_pulse = state_reg == FFTC_LEAD && lead_reg == '0;
  assign early_complete_pulse = state_reg == FFTC_EARLY;
  assign result_frame = state_reg == FFTC_FRAME || state_reg == FFTC_DONE;
  assign done_pulse = state_reg == FFTC_DONE;
  assign io_cycle_strobe = result_frame && memcfg == FFTC_CFG_DUAL;
  assign early_io_cycle_strobe = early_complete_pulse && memcfg == FFTC_CFG_DUAL;
  assign arith_overflow_flag = ovf_reg;
  assign result_real_bus = out_reg.re;
  assign result_imag_bus = out_reg.im;
  assign irq_set = {ovf_next & ~ovf_reg, done_pulse};

  // Pass 0 strides by 16, pass 1 by 4, pass 2 by 1. Results stay in
  // radix-4 digit-reversed order; reordering belongs to the memory side.
  genvar q;
  generate
    for (q = 0; q < 4; q++)
    begin : g_fly
      always_comb
      begin
        unique case (pass_reg)
          2'h0: fly_idx[q] = {2'(q), fly_reg};
          2'h1: fly_idx[q] = {fly_reg[3:2], 2'(q), fly_reg[1:0]};
          default: fly_idx[q] = {fly_reg, 2'(q)};
        endcase
        fly_in[q] = work_mem[fly_idx[q]];
      end
    end
  endgenerate

  fftc_dragonfly u_dragonfly (
    .in_vec(fly_in),
    .extra_shift(scale_reg && pass_reg == 2'h0),
    .inverse(~dir_reg),
    .out_vec(fly_out),
    .overflow(fly_ovf)
  );

  always_comb
  begin
    state_next = state_reg;
    scale_next = scale_reg;
    dir_next = dir_reg;
    ovf_next = ovf_reg;
    out_next = out_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_idx_next = rd_idx_reg;
    pass_next = pass_reg;
    fly_next = fly_reg;
    lead_next = lead_reg;
    in_next = in_mem;
    work_next = work_mem;
    if (input_write_strobe)
    begin
      in_next[wr_ptr_reg] = '{re: input_real_bus, im: input_imag_bus};
      wr_ptr_next = wr_ptr_reg + 6'h1;
    end
    unique case (state_reg)
      FFTC_IDLE:
        if (start_req && memcfg != FFTC_CFG_INVALID)
        begin
          scale_next = scale_sel_reg;
          dir_next = dir_sel_reg;
          pass_next = '0;
          fly_next = '0;
          lead_next = '0;
          if (continuous)
            state_next = FFTC_LEAD;
          else
          begin
            work_next = in_mem;
            state_next = FFTC_COMPUTE;
          end
        end
      FFTC_LEAD:
      begin
        if (mode_sample_pulse)
        begin
          scale_next = scale_sel_reg;
          dir_next = dir_sel_reg;
        end
        lead_next = lead_reg + 3'h1;
        if (lead_reg == `FFTC_MODE_LEAD - 3'h1)
        begin
          work_next = in_mem;
          pass_next = '0;
          fly_next = '0;
          state_next = FFTC_COMPUTE;
        end
      end
      FFTC_COMPUTE:
      begin
        for (int w = 0; w < 4; w++)
          work_next[fly_idx[w]] = fly_out[w];
        if (fly_ovf && !scale_reg)
          ovf_next = 1'b1;
        fly_next = fly_reg + 4'h1;
        if (fly_reg == `FFTC_LAST_FLY)
        begin
          pass_next = pass_reg + 2'h1;
          if (pass_reg == `FFTC_LAST_PASS)
            state_next = FFTC_EARLY;
        end
      end
      FFTC_EARLY:
      begin
        rd_idx_next = '0;
        out_next = work_mem[0];
        state_next = FFTC_FRAME;
      end
      FFTC_FRAME:
        if (result_read_strobe)
        begin
          rd_idx_next = rd_idx_reg + 6'h1;
          out_next = work_mem[rd_idx_next];
          if (rd_idx_reg == `FFTC_LAST_IDX)
            state_next = FFTC_DONE;
        end
      FFTC_DONE:
      begin
        ovf_next = 1'b0;
        lead_next = '0;
        state_next = continuous ? FFTC_LEAD : FFTC_IDLE;
      end
    endcase
    if (start_req && state_reg == FFTC_IDLE)
      ovf_next = 1'b0;
    if (core_reset_in)
    begin
      state_next = FFTC_IDLE;
      ovf_next = 1'b0;
      wr_ptr_next = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= FFTC_IDLE;
      scale_reg <= 1'b0;
      dir_reg <= 1'b1;
      ovf_reg <= 1'b0;
      out_reg <= '0;
      wr_ptr_reg <= '0;
      rd_idx_reg <= '0;
      pass_reg <= '0;
      fly_reg <= '0;
      lead_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      scale_reg <= scale_next;
      dir_reg <= dir_next;
      ovf_reg <= ovf_next;
      out_reg <= out_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_idx_reg <= rd_idx_next;
      pass_reg <= pass_next;
      fly_reg <= fly_next;
      lead_reg <= lead_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    in_mem <= in_next;
    work_mem <= work_next;
  end

endmodule : fftc_core

// *** logic/fftc_params.svh ***
`ifndef FFTC_PARAMS_SVH
`define FFTC_PARAMS_SVH

// ****************************************************************
// Register map (byte addresses) and field positions
// ****************************************************************
`define FFTC_ADDR_CTRL 32'h0000_0000
`define FFTC_ADDR_STATUS 32'h0000_0004
`define FFTC_ADDR_IRQ_STATUS 32'h0000_0008
`define FFTC_ADDR_IRQ_MASK 32'h0000_000c
`define FFTC_CTRL_START 0
`define FFTC_CTRL_SCALE 1
`define FFTC_CTRL_DIR 2
`define FFTC_CTRL_CFG_SECOND 3
`define FFTC_CTRL_CFG_FIRST 4
`define FFTC_CTRL_CORE_RESET 5
`define FFTC_STAT_BUSY 0
`define FFTC_STAT_OVF 1
`define FFTC_STAT_FRAME 2
`define FFTC_STAT_SCALE 3
`define FFTC_STAT_DIR 4
`define FFTC_IRQ_DONE 0
`define FFTC_IRQ_OVF 1
`define FFTC_IRQ_W 2
`define FFTC_RESP_OKAY 2'h0
`define FFTC_RESP_SLVERR 2'h2

// ****************************************************************
// Sizes and counts
// ****************************************************************
`define FFTC_PTS 64
`define FFTC_LAST_IDX 6'h3f
`define FFTC_LAST_FLY 4'hf
`define FFTC_LAST_PASS 2'h2
`define FFTC_MODE_LEAD 3'h4
`define FFTC_SHIFT_BASE 2
`define FFTC_SHIFT_EXTRA 3

`endif

// *** logic/fftc_pkg.sv ***
package fftc_pkg;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } fftc_cplx_t;

  typedef fftc_cplx_t [3:0] fftc_quad_t;

  typedef enum logic [1:0] {
    FFTC_CFG_INVALID,
    FFTC_CFG_SINGLE,
    FFTC_CFG_TRIPLE,
    FFTC_CFG_DUAL
  } fftc_memcfg_t;

  typedef enum logic [2:0] {
    FFTC_IDLE,
    FFTC_LEAD,
    FFTC_COMPUTE,
    FFTC_EARLY,
    FFTC_FRAME,
    FFTC_DONE
  } fftc_state_t;

endpackage : fftc_pkg

// *** logic/fftc_dragonfly.sv ***
`timescale 1ns/1ps
`include "fftc_params.svh"

// Radix-4 dragonfly with trivial rotations only (+-1, +-j). The twiddle
// multiplier of a full engine sits outside this stand-in datapath.
module fftc_dragonfly (
  input wire fftc_pkg::fftc_quad_t in_vec,
  input wire logic extra_shift,
  input wire logic inverse,
  output fftc_pkg::fftc_quad_t out_vec,
  output logic overflow
);
  import fftc_pkg::*;

  logic [3:0] ovf_vec;

  assign overflow = |ovf_vec;

  genvar m;
  generate
    for (m = 0; m < 4; m++)
    begin : g_out
      always_comb
      begin
        logic signed [19:0] acc_re;
        logic signed [19:0] acc_im;
        logic signed [19:0] xr;
        logic signed [19:0] xi;
        logic [1:0] k;
        acc_re = '0;
        acc_im = '0;
        xr = '0;
        xi = '0;
        k = '0;
        for (int n = 0; n < 4; n++)
        begin
          xr = 20'(in_vec[n].re);
          xi = 20'(in_vec[n].im);
          k = 2'((m * n) % 4);
          if (inverse)
            k = 2'(-k);
          unique case (k)
            2'h0:
            begin
              acc_re = acc_re + xr;
              acc_im = acc_im + xi;
            end
            2'h1:
            begin
              acc_re = acc_re + xi;
              acc_im = acc_im - xr;
            end
            2'h2:
            begin
              acc_re = acc_re - xr;
              acc_im = acc_im - xi;
            end
            2'h3:
            begin
              acc_re = acc_re - xi;
              acc_im = acc_im + xr;
            end
          endcase
        end
        // Rounding before the shift is what can push a full-scale sum out
        // of range; the extra bit of shift leaves enough headroom.
        if (extra_shift)
        begin
          acc_re = (acc_re + 20'sh4) >>> `FFTC_SHIFT_EXTRA;
          acc_im = (acc_im + 20'sh4) >>> `FFTC_SHIFT_EXTRA;
        end
        else
        begin
          acc_re = (acc_re + 20'sh2) >>> `FFTC_SHIFT_BASE;
          acc_im = (acc_im + 20'sh2) >>> `FFTC_SHIFT_BASE;
        end
        ovf_vec[m] = (acc_re > 20'sh07fff) || (acc_re < -20'sh08000) ||
                     (acc_im > 20'sh07fff) || (acc_im < -20'sh08000);
        out_vec[m].re = acc_re[15:0];
        out_vec[m].im = acc_im[15:0];
      end
    end
  endgenerate

endmodule : fftc_dragonfly

// *** logic/fftc_top_unused_placeholder_none.sv ***
`timescale 1ns/1ps

// *** bench/fftc_core_props.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Port-level checks of the transform sequencing
// ****************************************************************
module fftc_core_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic result_frame,
  input wire logic done_pulse,
  input wire logic early_complete_pulse,
  input wire logic busy,
  input wire logic arith_overflow_flag,
  input wire logic mode_sample_pulse,
  input wire logic io_cycle_strobe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_done_end;
    done_pulse |-> result_frame ##1 (!result_frame && !done_pulse);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done not at end of frame");
  property p_early;
    early_complete_pulse |=> (result_frame && !early_complete_pulse);
  endproperty
  a_early: assert property (p_early) else $error("early pulse not before frame");
  property p_frame_hold;
    (result_frame && !done_pulse) |=> result_frame;
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame dropped early");
  property p_busy_frame;
    (result_frame || early_complete_pulse) |-> busy;
  endproperty
  a_busy_frame: assert property (p_busy_frame) else $error("busy low while active");
  property p_busy_rise;
    $rose(busy) |-> $past(s_axi_awvalid && s_axi_awready);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose without start");
  property p_ovf_clear;
    done_pulse |=> !arith_overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow kept after done");
  property p_ovf_set;
    $rose(arith_overflow_flag) |-> (busy && !result_frame);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow outside compute");
  property p_io;
    io_cycle_strobe |-> result_frame;
  endproperty
  a_io: assert property (p_io) else $error("io strobe outside frame");
  property p_mode_lead;
    mode_sample_pulse |-> ##52 early_complete_pulse;
  endproperty
  a_mode_lead: assert property (p_mode_lead) else $error("mode pulse lead wrong");
endmodule : fftc_core_props

bind fftc_core fftc_core_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .result_frame, .done_pulse, .early_complete_pulse, .busy, .arith_overflow_flag,
  .mode_sample_pulse, .io_cycle_strobe);

// *** bench/fftc_host_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Host logic feeding samples and collecting results
// ****************************************************************
module fftc_host_model (
  input wire logic aclk,
  input wire logic result_frame,
  input wire logic [15:0] result_real_bus,
  input wire logic [15:0] result_imag_bus,
  output logic input_write_strobe,
  output logic [15:0] input_real_bus,
  output logic [15:0] input_imag_bus,
  output logic result_read_strobe
);
  logic [15:0] vec_re [64];
  logic [15:0] vec_im [64];
  logic [15:0] res_re [64];
  logic [15:0] res_im [64];

  initial
  begin
    input_write_strobe = 1'b0;
    input_real_bus = 16'h0000;
    input_imag_bus = 16'h0000;
    result_read_strobe = 1'b0;
  end

  task automatic load_vec();
    for (int k = 0; k < 64; k++)
    begin
      input_write_strobe <= 1'b1;
      input_real_bus <= vec_re[k];
      input_imag_bus <= vec_im[k];
      @(posedge aclk);
    end
    input_write_strobe <= 1'b0;
    // Idle buses show the inverse so a stale sample can never pass as fresh.
    input_real_bus <= ~input_real_bus;
    input_imag_bus <= ~input_imag_bus;
  endtask : load_vec

  // A gap above zero models a slow reader that drops its strobe between samples.
  task automatic unload_vec(input int gap);
    for (int w = 0; w < 300 && result_frame !== 1'b1; w++)
      @(posedge aclk);
    for (int k = 0; k < 64; k++)
    begin
      result_read_strobe <= 1'b1;
      @(posedge aclk);
      res_re[k] = result_real_bus;
      res_im[k] = result_imag_bus;
      if (gap > 0)
      begin
        result_read_strobe <= 1'b0;
        repeat (gap) @(posedge aclk);
      end
    end
    result_read_strobe <= 1'b0;
  endtask : unload_vec
endmodule : fftc_host_model

// *** bench/fftc_core_tb.sv ***
`timescale 1ns/1ps
`include "fftc_params.svh"

module fftc_core_tb;
  import fftc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic input_write_strobe, result_read_strobe, result_frame, done_pulse, busy, irq;
  logic [15:0] input_real_bus, input_imag_bus, result_real_bus, result_imag_bus;
  logic early_complete_pulse, arith_overflow_flag, mode_sample_pulse;
  logic io_cycle_strobe, early_io_cycle_strobe;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] ws;
  int err_count = 0;
  int compares = 0;

  always #10 aclk = ~aclk;

  fftc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .input_write_strobe, .input_real_bus, .input_imag_bus, .result_read_strobe,
    .result_real_bus, .result_imag_bus, .result_frame, .done_pulse, .early_complete_pulse, .busy,
    .arith_overflow_flag, .mode_sample_pulse, .io_cycle_strobe, .early_io_cycle_strobe, .irq);

  fftc_host_model host (.aclk, .result_frame, .result_real_bus, .result_imag_bus,
    .input_write_strobe, .input_real_bus, .input_imag_bus, .result_read_strobe);

  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int w = 0; w < 50 && !got; w++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      got = (s_axi_bvalid === 1'b1);
      ws = s_axi_bresp;
    end
    // Ready stays high between calls, so a back-to-back call never drives it twice in one step.
    check(got, 1'b1);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int w = 0; w < 50 && !got; w++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      got = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    check(got, 1'b1);
  endtask : axi_read

  // Looks before waiting, because a mode pulse can land on the edge that ends a bus write.
  task automatic wait_for(input bit mode);
    for (int w = 0; w < 300; w++)
    begin
      if (mode ? mode_sample_pulse === 1'b1 : early_complete_pulse === 1'b1)
        return;
      @(posedge aclk);
    end
    check(32'h0, 32'h1);
  endtask : wait_for

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // A flat vector folds to one bin; the overflow vector drives all four butterfly legs to full scale.
  task automatic set_vec(input bit ovf);
    logic [15:0] ore [4];
    logic [15:0] oim [4];
    ore = '{16'h7fff, 16'h0000, 16'h8000, 16'h0000};
    oim = '{16'h0000, 16'h7fff, 16'h0000, 16'h8000};
    for (int k = 0; k < 64; k++)
    begin
      host.vec_re[k] = ovf ? ore[k / 16] : 16'h0100;
      host.vec_im[k] = ovf ? oim[k / 16] : 16'hff00;
    end
    host.load_vec();
  endtask : set_vec

  task automatic run_vec(input logic [31:0] ctrl, input logic [15:0] ere,
    input logic [15:0] eim, input logic eovf, input bit chk);
    // Start captures the settings already held, so they are written first.
    axi_write(`FFTC_ADDR_CTRL, ctrl);
    axi_write(`FFTC_ADDR_CTRL, ctrl | 32'h1);
    wait_for(1'b0);
    check(arith_overflow_flag, eovf);
    check(busy, 1'b1);
    host.unload_vec(0);
    @(posedge aclk);
    check(done_pulse, 1'b1);
    for (int k = 0; k < 64 && chk; k++)
    begin
      check(host.res_re[k], k == 0 ? ere : 16'h0000);
      check(host.res_im[k], k == 0 ? eim : 16'h0000);
    end
    @(posedge aclk);
    check(arith_overflow_flag, 1'b0);
    check(busy, 1'b0);
    axi_read(`FFTC_ADDR_STATUS, rd, rs);
    check(rd & 32'h18, (ctrl & 32'h6) << 2);
  endtask : run_vec

  initial
  begin
    #1_000_000;
    err_count++;
    conclude();
  end

  initial
  begin
    do_reset();
    axi_read(`FFTC_ADDR_STATUS, rd, rs);
    check(rd, 32'h10);
    check(rs, `FFTC_RESP_OKAY);
    axi_read(32'h10, rd, rs);
    check(rs, `FFTC_RESP_SLVERR);
    check(rd, 32'h0);
    axi_write(32'h10, 32'h0);
    check(ws, `FFTC_RESP_SLVERR);
    axi_write(`FFTC_ADDR_CTRL, 32'h0);
    check(ws, `FFTC_RESP_OKAY);
    axi_write(`FFTC_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    check(busy, 1'b0);
    axi_write(`FFTC_ADDR_IRQ_MASK, 32'h1);
    set_vec(1'b0);
    run_vec(32'h0c, 16'h0100, 16'hff00, 1'b0, 1'b1);
    run_vec(32'h0e, 16'h0080, 16'hff80, 1'b0, 1'b1);
    run_vec(32'h08, 16'h0100, 16'hff00, 1'b0, 1'b1);
    check(irq, 1'b1);
    axi_write(`FFTC_ADDR_IRQ_STATUS, 32'h1);
    check(irq, 1'b0);
    axi_write(`FFTC_ADDR_IRQ_MASK, 32'h0);
    set_vec(1'b1);
    run_vec(32'h08, 16'h0, 16'h0, 1'b1, 1'b0);
    run_vec(32'h0a, 16'h0, 16'h0, 1'b0, 1'b0);
    check(irq, 1'b0);
    axi_read(`FFTC_ADDR_IRQ_STATUS, rd, rs);
    check(rd, 32'h3);
    axi_write(`FFTC_ADDR_IRQ_STATUS, 32'h3);
    axi_read(`FFTC_ADDR_IRQ_STATUS, rd, rs);
    check(rd, 32'h0);
    set_vec(1'b0);
    axi_write(`FFTC_ADDR_CTRL, 32'h18);
    axi_write(`FFTC_ADDR_CTRL, 32'h19);
    wait_for(1'b1);
    axi_read(`FFTC_ADDR_STATUS, rd, rs);
    check(rd, 32'h1);
    axi_write(`FFTC_ADDR_CTRL, 32'h1a);
    wait_for(1'b0);
    check(early_io_cycle_strobe, 1'b1);
    @(posedge aclk);
    check(io_cycle_strobe, 1'b1);
    host.unload_vec(1);
    wait_for(1'b1);
    axi_read(`FFTC_ADDR_STATUS, rd, rs);
    check(rd, 32'h9);
    do_reset();
    axi_write(`FFTC_ADDR_CTRL, 32'h10);
    axi_write(`FFTC_ADDR_CTRL, 32'h11);
    wait_for(1'b1);
    check(busy, 1'b1);
    wait_for(1'b0);
    check(early_io_cycle_strobe, 1'b0);
    do_reset();
    conclude();
  end
endmodule : fftc_core_tb
